// ==== core/acc_pkg.sv ====
// Shared types and constants for the accumulator, logic and port datapath
package acc_pkg;

  localparam int NIB_W      = 4;
  localparam int ROM_W      = 10;
  localparam int ROM_ADDR_W = 10;
  localparam int PAGE_W     = 2;
  localparam int REG_IDX_W  = 4;
  localparam int NUM_REGS   = 16;
  localparam int NUM_PORTS  = 5;
  localparam int PORT_IDX_W = 3;

  localparam logic [NIB_W-1:0]      ACC_RESET   = 4'h0;
  localparam logic [NIB_W-1:0]      NIB_ZERO    = 4'h0;
  localparam logic [NIB_W-1:0]      NIB_ONE     = 4'h1;
  localparam logic [PAGE_W-1:0]     PAGE_RESET  = 2'h0;
  localparam logic [PORT_IDX_W-1:0] PORT_IDX_2  = 3'h2;
  localparam logic [PORT_IDX_W-1:0] PORT_IDX_MAX = 3'h4;
  localparam int                    MSB         = 3;
  localparam int                    ROM_HI_LSB  = 4;
  localparam int                    ROM_LO_LSB  = 0;

  // Operation select decoded from the instruction stream
  typedef enum logic [4:0] {
    OP_NOP       = 5'h00,
    OP_OR_REG    = 5'h01,
    OP_OR_ROM_H  = 5'h02,
    OP_OR_ROM_L  = 5'h03,
    OP_OR_IMM    = 5'h04,
    OP_XOR_REG   = 5'h05,
    OP_XOR_ROM_H = 5'h06,
    OP_XOR_ROM_L = 5'h07,
    OP_XOR_IMM   = 5'h08,
    OP_INC       = 5'h09,
    OP_RL        = 5'h0a,
    OP_ROT_ZRST  = 5'h0b,
    OP_IN_PORT   = 5'h0c,
    OP_OUT_PORT  = 5'h0d,
    OP_AND_PORT  = 5'h0e,
    OP_OR_PORT   = 5'h0f,
    OP_XOR_PORT  = 5'h10,
    OP_OUT_IMM8  = 5'h11,
    OP_MOV_REG   = 5'h12,
    OP_MOV_ROM_H = 5'h13,
    OP_MOV_ROM_L = 5'h14,
    OP_MOV_IMM   = 5'h15
  } op_type;

  typedef struct packed {
    logic                  valid;
    op_type                op;
    logic                  bank;
    logic [REG_IDX_W-1:0]  reg_idx;
    logic [PORT_IDX_W-1:0] port_idx;
    logic [NIB_W-1:0]      imm_nibble;
    logic [2*NIB_W-1:0]    imm_byte;
  } instr_type;

  typedef struct packed {
    logic [NIB_W-1:0] acc;
    logic             carry_flag;
  } acc_state_type;

  typedef struct packed {
    logic [NUM_PORTS-1:0][NIB_W-1:0] bank1;
    logic [NUM_PORTS-1:0][NIB_W-1:0] bank0;
  } port_bus_type;

endpackage

// ==== core/port_latch_bank.sv ====
// Output latches of both port banks, held until written
`timescale 1ns/1ns
module port_latch_bank
  import acc_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire logic                  wr_single,
  input  wire logic                  wr_pair,
  input  wire logic                  wr_bank,
  input  wire logic [PORT_IDX_W-1:0] wr_idx,
  input  wire logic [NIB_W-1:0]      wr_nibble,
  input  wire logic [2*NIB_W-1:0]    wr_byte,
  output port_bus_type               latch_q
);

  typedef struct packed {
    port_bus_type lat;
  } latch_state_type;

  latch_state_type state_r;
  latch_state_type state_nxt;

  always_comb begin
    state_nxt = state_r;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (wr_idx == PORT_IDX_W'(i)) begin
        if (wr_single && wr_bank) begin
          state_nxt.lat.bank1[i] = wr_nibble;
        end
        if (wr_single && !wr_bank) begin
          state_nxt.lat.bank0[i] = wr_nibble;
        end
        if (wr_pair) begin
          state_nxt.lat.bank1[i] = wr_byte[2*NIB_W-1:NIB_W];
          state_nxt.lat.bank0[i] = wr_byte[NIB_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign latch_q = state_r.lat;

endmodule

// ==== core/acc_datapath.sv ====
// Accumulator logic, rotate, port and table-read datapath
`timescale 1ns/1ns
module acc_datapath
  import acc_pkg::*;
(
  input  wire logic                            clk,
  input  wire logic                            rst_b,
  input  instr_type                            instr,
  input  wire logic [PAGE_W-1:0]               rom_page_select_reg,
  input  wire logic [NUM_REGS-1:0][NIB_W-1:0]  reg_bank0,
  input  wire logic [NUM_REGS-1:0][NIB_W-1:0]  reg_bank1,
  output logic      [ROM_ADDR_W-1:0]           rom_addr,
  input  wire logic [ROM_W-1:0]                rom_data,
  input  port_bus_type                         port_pins,
  output port_bus_type                         port_latch,
  output logic      [NIB_W-1:0]                acc,
  output logic                                 carry_flag,
  output logic                                 internal_reset,
  output logic                                 bad_port
);

  typedef struct packed {
    acc_state_type             a;
    logic                      ireset;
    logic                      badp;
    port_bus_type              pin_s1;
    port_bus_type              pin_s2;
    port_bus_type              pin_s3;
    port_bus_type              pin_stable;
  } dp_state_type;

  dp_state_type state_r;
  dp_state_type state_nxt;

  // Picks one nibble of a port bus by bank and index
  function automatic logic [NIB_W-1:0] pick_port(
    input port_bus_type          pb,
    input logic                  bank,
    input logic [PORT_IDX_W-1:0] idx
  );
    logic [NIB_W-1:0] v;
    v = NIB_ZERO;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (idx == PORT_IDX_W'(i)) begin
        v = bank ? pb.bank1[i] : pb.bank0[i];
      end
    end
    return v;
  endfunction

  // Only indexes 0, 1, 3 and 4 exist
  function automatic logic port_ok(input logic [PORT_IDX_W-1:0] idx);
    return (idx != PORT_IDX_2) && (idx <= PORT_IDX_MAX);
  endfunction

  logic [NIB_W-1:0] reg_val;
  logic [NIB_W-1:0] rom_hi;
  logic [NIB_W-1:0] rom_lo;
  logic [NIB_W-1:0] port_val;
  logic [NIB_W-1:0] a_old;
  logic             out_single;
  logic             out_pair;

  assign rom_addr = {rom_page_select_reg, reg_bank1[0], reg_bank0[0]};

  assign reg_val = instr.bank ? reg_bank1[instr.reg_idx] : reg_bank0[instr.reg_idx];
  // nibble select, bits 9 and 8 unused
  assign rom_hi  = rom_data[ROM_HI_LSB +: NIB_W];
  assign rom_lo  = rom_data[ROM_LO_LSB +: NIB_W];
  assign port_val = pick_port(state_r.pin_stable, instr.bank, instr.port_idx);
  assign a_old   = state_r.a.acc;

  assign out_single = instr.valid && (instr.op == OP_OUT_PORT) && port_ok(instr.port_idx);
  assign out_pair   = instr.valid && (instr.op == OP_OUT_IMM8) && port_ok(instr.port_idx);

  port_latch_bank u_latch (
    .clk       (clk),
    .rst_b     (rst_b),
    .wr_single (out_single),
    .wr_pair   (out_pair),
    .wr_bank   (instr.bank),
    .wr_idx    (instr.port_idx),
    .wr_nibble (a_old),
    .wr_byte   (instr.imm_byte),
    .latch_q   (port_latch)
  );

  always_comb begin
    state_nxt = state_r;
    state_nxt.ireset = 1'b0;
    state_nxt.badp   = 1'b0;
    // Pins are asynchronous; accept a change once two stages agree
    state_nxt.pin_s1 = port_pins;
    state_nxt.pin_s2 = state_r.pin_s1;
    state_nxt.pin_s3 = state_r.pin_s2;
    if (state_r.pin_s2 == state_r.pin_s3) begin
      state_nxt.pin_stable = state_r.pin_s3;
    end
    if (instr.valid) begin
      case (instr.op)
        OP_OR_REG: begin
          state_nxt.a.acc = a_old | reg_val;
          state_nxt.a.carry_flag = 1'b0;
        end
        OP_OR_ROM_H: begin
          state_nxt.a.acc = a_old | rom_hi;
          state_nxt.a.carry_flag = 1'b0;
        end
        OP_OR_ROM_L: begin
          state_nxt.a.acc = a_old | rom_lo;
          state_nxt.a.carry_flag = 1'b0;
        end
        OP_OR_IMM: begin
          state_nxt.a.acc = a_old | instr.imm_nibble;
          state_nxt.a.carry_flag = 1'b0;
        end
        OP_XOR_REG: begin
          state_nxt.a.acc = a_old ^ reg_val;
          state_nxt.a.carry_flag = a_old[MSB] & reg_val[MSB];
        end
        OP_XOR_ROM_H: begin
          state_nxt.a.acc = a_old ^ rom_hi;
          state_nxt.a.carry_flag = a_old[MSB] & rom_hi[MSB];
        end
        OP_XOR_ROM_L: begin
          state_nxt.a.acc = a_old ^ rom_lo;
          state_nxt.a.carry_flag = a_old[MSB] & rom_lo[MSB];
        end
        OP_XOR_IMM: begin
          state_nxt.a.acc = a_old ^ instr.imm_nibble;
          state_nxt.a.carry_flag = a_old[MSB] & instr.imm_nibble[MSB];
        end
        OP_INC: begin
          state_nxt.a.acc = a_old + NIB_ONE;
          state_nxt.a.carry_flag = (a_old + NIB_ONE) == NIB_ZERO;
        end
        OP_RL: begin
          state_nxt.a.acc = {a_old[MSB-1:0], a_old[MSB]};
          state_nxt.a.carry_flag = a_old[MSB];
        end
        OP_ROT_ZRST: begin
          if (a_old == NIB_ZERO) begin
            state_nxt.ireset = 1'b1;
          end else begin
            state_nxt.a.acc = {a_old[MSB-1:0], a_old[MSB]};
            state_nxt.a.carry_flag = a_old[MSB];
          end
        end
        OP_IN_PORT: begin
          if (port_ok(instr.port_idx)) begin
            state_nxt.a.acc = port_val;
            state_nxt.a.carry_flag = 1'b0;
          end else begin
            state_nxt.badp = 1'b1;
          end
        end
        OP_AND_PORT: begin
          if (port_ok(instr.port_idx)) begin
            state_nxt.a.acc = a_old & port_val;
            state_nxt.a.carry_flag = a_old[MSB] & port_val[MSB];
          end else begin
            state_nxt.badp = 1'b1;
          end
        end
        OP_OR_PORT: begin
          if (port_ok(instr.port_idx)) begin
            state_nxt.a.acc = a_old | port_val;
            state_nxt.a.carry_flag = 1'b0;
          end else begin
            state_nxt.badp = 1'b1;
          end
        end
        OP_XOR_PORT: begin
          if (port_ok(instr.port_idx)) begin
            state_nxt.a.acc = a_old ^ port_val;
            state_nxt.a.carry_flag = a_old[MSB] & port_val[MSB];
          end else begin
            state_nxt.badp = 1'b1;
          end
        end
        OP_OUT_PORT, OP_OUT_IMM8: begin
          state_nxt.badp = !port_ok(instr.port_idx);
        end
        OP_MOV_REG: begin
          state_nxt.a.acc = reg_val;
          state_nxt.a.carry_flag = 1'b0;
        end
        OP_MOV_ROM_H: begin
          state_nxt.a.acc = rom_hi;
          state_nxt.a.carry_flag = 1'b0;
        end
        OP_MOV_ROM_L: begin
          state_nxt.a.acc = rom_lo;
          state_nxt.a.carry_flag = 1'b0;
        end
        OP_MOV_IMM: begin
          state_nxt.a.acc = instr.imm_nibble;
          state_nxt.a.carry_flag = 1'b0;
        end
        default: begin
          state_nxt.a = state_r.a;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign acc            = state_r.a.acc;
  assign carry_flag     = state_r.a.carry_flag;
  assign internal_reset = state_r.ireset;
  assign bad_port       = state_r.badp;

endmodule

// ==== tb/acc_props.sv ====
// Concurrent checks on the accumulator datapath ports
`timescale 1ns/1ns
module acc_props
  import acc_pkg::*;
(
  input  wire logic                           clk,
  input  wire logic                           rst_b,
  input  instr_type                           instr,
  input  wire logic [PAGE_W-1:0]              rom_page_select_reg,
  input  wire logic [NUM_REGS-1:0][NIB_W-1:0] reg_bank0,
  input  wire logic [NUM_REGS-1:0][NIB_W-1:0] reg_bank1,
  input  wire logic [ROM_ADDR_W-1:0]          rom_addr,
  input  port_bus_type                        port_latch,
  input  wire logic [NIB_W-1:0]               acc,
  input  wire logic                           carry_flag,
  input  wire logic                           internal_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_addr;
    rom_addr == {rom_page_select_reg, reg_bank1[0], reg_bank0[0]};
  endproperty
  a_addr: assert property (p_addr) else $error("table address wrong");
  property p_inc;
    instr.valid && instr.op == OP_INC |=> acc == $past(acc) + 4'h1 && carry_flag == (acc == 4'h0);
  endproperty
  a_inc: assert property (p_inc) else $error("increment wrong");
  property p_rl;
    instr.valid && instr.op == OP_RL |=> acc == {$past(acc[2:0]), $past(acc[3])}
      && carry_flag == $past(acc[3]);
  endproperty
  a_rl: assert property (p_rl) else $error("rotate wrong");
  property p_rot_zero;
    instr.valid && instr.op == OP_ROT_ZRST && acc == 4'h0
      |=> internal_reset && acc == 4'h0 ##1 !internal_reset;
  endproperty
  a_rot_zero: assert property (p_rot_zero) else $error("zero rotate no reset pulse");
  property p_or_imm;
    instr.valid && instr.op == OP_OR_IMM |=> acc == ($past(acc) | $past(instr.imm_nibble)) && !carry_flag;
  endproperty
  a_or_imm: assert property (p_or_imm) else $error("or immediate wrong");
  property p_xor_imm;
    instr.valid && instr.op == OP_XOR_IMM |=> acc == ($past(acc) ^ $past(instr.imm_nibble))
      && carry_flag == ($past(acc[3]) & $past(instr.imm_nibble[3]));
  endproperty
  a_xor_imm: assert property (p_xor_imm) else $error("xor immediate wrong");
  property p_mov_imm;
    instr.valid && instr.op == OP_MOV_IMM |=> acc == $past(instr.imm_nibble) && !carry_flag;
  endproperty
  a_mov_imm: assert property (p_mov_imm) else $error("move immediate wrong");
  property p_out8;
    instr.valid && instr.op == OP_OUT_IMM8 && instr.port_idx == 3'h3
      |=> {port_latch.bank1[3], port_latch.bank0[3]} == $past(instr.imm_byte);
  endproperty
  a_out8: assert property (p_out8) else $error("port pair write wrong");
endmodule

bind acc_datapath acc_props u_props (.clk(clk), .rst_b(rst_b), .instr(instr),
  .rom_page_select_reg(rom_page_select_reg), .reg_bank0(reg_bank0), .reg_bank1(reg_bank1),
  .rom_addr(rom_addr), .port_latch(port_latch), .acc(acc), .carry_flag(carry_flag),
  .internal_reset(internal_reset));

// ==== tb/rom_port_model.sv ====
// Program memory and port pins seen from the far side
`timescale 1ns/1ns
module rom_port_model
  import acc_pkg::*;
#(
  parameter logic [ROM_W-1:0] ROM_MASK = 10'h2d9
) (
  input  wire logic [ROM_ADDR_W-1:0] rom_addr,
  output logic      [ROM_W-1:0]      rom_data,
  input  port_bus_type               port_latch,
  output port_bus_type               port_pins
);
  // Word content derived from address, so every address differs
  assign rom_data  = rom_addr ^ ROM_MASK;
  // Pins follow what the latches drive
  assign port_pins = port_latch;
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the accumulator datapath
`timescale 1ns/1ns
module tb;
  import acc_pkg::*;
  logic                           clk;
  logic                           rst_b;
  instr_type                      instr;
  logic [PAGE_W-1:0]              page;
  logic [NUM_REGS-1:0][NIB_W-1:0] rb0;
  logic [NUM_REGS-1:0][NIB_W-1:0] rb1;
  logic [ROM_ADDR_W-1:0]          rom_addr;
  logic [ROM_W-1:0]               rom_data;
  port_bus_type                   pins;
  port_bus_type                   latch;
  logic [NIB_W-1:0]               acc;
  logic                           carry;
  logic                           ireset;
  logic                           bad_port;
  int                             bad_count = 0;
  int                             checks = 0;

  acc_datapath dut (.clk(clk), .rst_b(rst_b), .instr(instr), .rom_page_select_reg(page),
    .reg_bank0(rb0), .reg_bank1(rb1), .rom_addr(rom_addr), .rom_data(rom_data),
    .port_pins(pins), .port_latch(latch), .acc(acc), .carry_flag(carry),
    .internal_reset(ireset), .bad_port(bad_port));
  rom_port_model far (.rom_addr(rom_addr), .rom_data(rom_data), .port_latch(latch),
    .port_pins(pins));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task chk(string nm, logic [9:0] s, logic [9:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task put(op_type o, logic b, logic [3:0] r, logic [2:0] p, logic [3:0] n, logic [7:0] y);
    @(negedge clk);
    instr = '{1'b1, o, b, r, p, n, y};
  endtask
  task stop;
    @(negedge clk);
    instr.valid = 1'b0;
  endtask
  task ac(logic [3:0] ea, logic ec);
    chk("acc", {6'h0, acc}, {6'h0, ea});
    chk("carry", {9'h0, carry}, {9'h0, ec});
  endtask
  task mv(logic [3:0] n);
    put(OP_MOV_IMM, 1'b0, 4'h0, 3'h0, n, 8'h00);
  endtask

  task t_imm;
    mv(4'h8);
    put(OP_XOR_IMM, 1'b0, 4'h0, 3'h0, 4'h9, 8'h00);
    stop; ac(4'h1, 1'b1);
    mv(4'h3);
    put(OP_OR_IMM, 1'b0, 4'h0, 3'h0, 4'h4, 8'h00);
    stop; ac(4'h7, 1'b0);
    mv(4'hf);
    put(OP_INC, 1'b0, 4'h0, 3'h0, 4'h0, 8'h00);
    stop; ac(4'h0, 1'b1);
    put(OP_INC, 1'b0, 4'h0, 3'h0, 4'h0, 8'h00);
    stop; ac(4'h1, 1'b0);
  endtask
  task t_reg;
    rb1[5] = 4'ha;
    rb0[5] = 4'h6;
    put(OP_MOV_REG, 1'b1, 4'h5, 3'h0, 4'h0, 8'h00);
    stop; ac(4'ha, 1'b0);
    // Back to back, each step uses the previous result
    put(OP_XOR_REG, 1'b0, 4'h5, 3'h0, 4'h0, 8'h00);
    put(OP_OR_REG, 1'b1, 4'h5, 3'h0, 4'h0, 8'h00);
    stop; ac(4'he, 1'b0);
  endtask
  task t_rom;
    page = 2'h2;
    rb1[0] = 4'h3;
    rb0[0] = 4'hc;
    put(OP_MOV_ROM_H, 1'b0, 4'h0, 3'h0, 4'h0, 8'h00);
    stop; ac(4'he, 1'b0);
    chk("rom_addr", rom_addr, 10'h23c);
    put(OP_XOR_ROM_H, 1'b0, 4'h0, 3'h0, 4'h0, 8'h00);
    stop; ac(4'h0, 1'b1);
    put(OP_MOV_ROM_L, 1'b0, 4'h0, 3'h0, 4'h0, 8'h00);
    stop; ac(4'h5, 1'b0);
    put(OP_OR_ROM_H, 1'b0, 4'h0, 3'h0, 4'h0, 8'h00);
    put(OP_XOR_ROM_L, 1'b0, 4'h0, 3'h0, 4'h0, 8'h00);
    stop; ac(4'ha, 1'b0);
    put(OP_OR_ROM_L, 1'b0, 4'h0, 3'h0, 4'h0, 8'h00);
    stop; ac(4'hf, 1'b0);
  endtask
  task t_rot;
    mv(4'h9);
    put(OP_RL, 1'b0, 4'h0, 3'h0, 4'h0, 8'h00);
    stop; ac(4'h3, 1'b1);
    put(OP_ROT_ZRST, 1'b0, 4'h0, 3'h0, 4'h0, 8'h00);
    stop; ac(4'h6, 1'b0);
    chk("ireset", {9'h0, ireset}, 10'h0);
    mv(4'h0);
    put(OP_ROT_ZRST, 1'b0, 4'h0, 3'h0, 4'h0, 8'h00);
    stop; chk("ireset", {9'h0, ireset}, 10'h1);
    chk("acc", {6'h0, acc}, 10'h0);
  endtask
  task t_port;
    put(OP_OUT_IMM8, 1'b0, 4'h0, 3'h3, 4'h0, 8'h5a);
    mv(4'h3);
    put(OP_OUT_PORT, 1'b0, 4'h0, 3'h4, 4'h0, 8'h00);
    stop; chk("latch_b1_3", {6'h0, latch.bank1[3]}, 10'h5);
    chk("latch_b0_3", {6'h0, latch.bank0[3]}, 10'ha);
    // Pins pass a synchroniser, so let them settle
    repeat (6) stop;
    put(OP_IN_PORT, 1'b1, 4'h0, 3'h3, 4'h0, 8'h00);
    stop; ac(4'h5, 1'b0);
    mv(4'hc);
    put(OP_AND_PORT, 1'b0, 4'h0, 3'h3, 4'h0, 8'h00);
    stop; ac(4'h8, 1'b1);
    put(OP_OR_PORT, 1'b1, 4'h0, 3'h3, 4'h0, 8'h00);
    stop; ac(4'hd, 1'b0);
    put(OP_XOR_PORT, 1'b0, 4'h0, 3'h3, 4'h0, 8'h00);
    put(OP_OUT_PORT, 1'b0, 4'h0, 3'h2, 4'h0, 8'h00);
    stop; ac(4'h7, 1'b1);
    chk("bad_port", {9'h0, bad_port}, 10'h1);
    chk("latch_b0_4", {6'h0, latch.bank0[4]}, 10'h3);
    chk("latch_b0_2", {6'h0, latch.bank0[2]}, 10'h0);
  endtask

  task print_verdict;
    if (bad_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #8000;
    bad_count++;
    print_verdict;
  end

  initial begin
    rst_b = 1'b0;
    instr = '0;
    page = 2'h0;
    rb0 = '0;
    rb1 = '0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    t_imm;
    t_reg;
    t_rom;
    t_rot;
    t_port;
    print_verdict;
  end
endmodule
